// ==== core/touch_cdc_ctrl.sv ====
/*
 * Power mode control, conversion cadence, per-stage input routing and
 * touch registration for the capacitance converter.
 * Assumes the serial interface engine presents decoded word accesses on
 * the reg_* port, and the converter core sits on the same clock.
 */
// Notes on behaviour
// - A threshold crossing registers activation and sets interrupt status bits on its own.
// - Control word bits 1:0 select mode: 00 full power, 10 low power.
// - Codes 01 or 11 in the mode field mean complete shutdown.
// - The mode field resets to 00, so operation starts at full power.
// - Shutdown powers everything down and runs no conversions.
// - Full power keeps every section powered, never a reduced state.
// - Full power converts at a fixed cadence, touched or not.
// - Untouched results in full power update the ambient baseline.
// - Low power idles reduced, waking per 200-800 ms interval to convert.
// - Once touched in low power, a sequence starts every 25 ms.
// - After touches stop, the timeout field sets the wait before idling.
// - Each stage holds its own route, offset, sensitivity and limit settings.
// - Each pin can go to positive input, negative input, or float.
// - Each pin can instead be tied to the shield drive.
// - Positive-routed inputs give a falling code on activation.
// - Negative-routed inputs give a rising code on activation.
// - Each stage register holds two routing bits per input pin.
// - Wake interval field bits 3:2: 200, 400, 600 or 800 ms.
`timescale 1ns/1ns
`default_nettype none
module touch_cdc_ctrl #(
    parameter int TOUCHED_CYCLES = touch_cdc_pkg::TOUCHED_CYCLES,
    parameter int WAKE_STEP_CYCLES = touch_cdc_pkg::WAKE_STEP_CYCLES,
    parameter int FULL_SEQ_CYCLES = touch_cdc_pkg::FULL_SEQ_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic conv_done_i,
    input wire logic [15:0] conv_result_i,
    output logic conv_start_o,
    output logic [2:0] conv_stage_o,
    output logic [15:0] sense_route_o,
    output logic cdc_power_on_o,
    output logic reduced_power_o,
    output logic ambient_update_o,
    output logic [7:0] int_status_o
);
    typedef enum logic [3:0] {
        PS_FULL = 4'b0001,
        PS_LP_IDLE = 4'b0010,
        PS_LP_TOUCH = 4'b0100,
        PS_SHUT = 4'b1000
    } pwr_state_e;
    typedef enum logic [1:0] {
        SQ_IDLE = 2'b01,
        SQ_BUSY = 2'b10
    } seq_state_e;

    logic [15:0] pwr_ctrl_q;
    logic [15:0] amb_ctrl0_q;
    logic [15:0] stage_cfg_q [32];
    logic [15:0] baseline_q [8];
    logic [7:0] base_valid_q;
    logic [7:0] touch_q;
    logic [7:0] int_q;
    pwr_state_e pstate_q;
    pwr_state_e pstate_d;
    seq_state_e sq_q;
    logic [2:0] stage_q;
    logic seq_done_q;
    logic [31:0] per_cnt_q;
    logic [31:0] period_len;
    localparam int TIMEOUT_W_L = touch_cdc_pkg::TIMEOUT_W;
    logic [TIMEOUT_W_L-1:0] idle_cnt_q;
    logic tick;
    logic seq_start;
    logic eval;
    logic act_w;
    logic shut_req;
    logic [1:0] wake_sel;
    logic [3:0] idle_entry_timeout;
    logic stage_sel;
    logic [4:0] stage_idx;
    logic int_clr;

    // Positive polarity if any pin of the stage drives the positive input
    function automatic logic route_is_pos(input logic [15:0] route);
        logic pos;
        pos = 1'b0;
        for (int p = 0; p < touch_cdc_pkg::NUM_PINS; p++) begin
            if (route[2*p +: 2] == touch_cdc_pkg::ROUTE_POS) begin
                pos = 1'b1;
            end
        end
        return pos;
    endfunction : route_is_pos

    // Signed excursion from baseline in the activating direction
    function automatic logic crossed(input logic [15:0] route, input logic [15:0] res,
                                     input logic [15:0] ofs, input logic [15:0] base,
                                     input logic [15:0] thr);
        logic [16:0] adj;
        logic signed [17:0] delta;
        adj = {1'b0, res} + {1'b0, ofs};
        if (route_is_pos(route)) begin
            delta = $signed({2'b00, base}) - $signed({2'b00, adj[15:0]});
        end else begin
            delta = $signed({2'b00, adj[15:0]}) - $signed({2'b00, base});
        end
        return delta > $signed({2'b00, thr});
    endfunction : crossed

    assign shut_req = pwr_ctrl_q[touch_cdc_pkg::PWR_MODE_LSB];
    assign wake_sel = pwr_ctrl_q[touch_cdc_pkg::WAKE_LSB +: 2];
    assign idle_entry_timeout = amb_ctrl0_q[touch_cdc_pkg::TIMEOUT_LSB +: TIMEOUT_W_L];
    assign stage_sel = reg_addr_i[11:5] == touch_cdc_pkg::ADDR_STAGE_BASE[11:5];
    assign stage_idx = reg_addr_i[4:0];
    assign int_clr = reg_wr_i && reg_addr_i == touch_cdc_pkg::ADDR_INT_STATUS;

    // Register writes
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pwr_ctrl_q <= touch_cdc_pkg::PWR_CTRL_RST;
            amb_ctrl0_q <= touch_cdc_pkg::AMB_CTRL0_RST;
        end else if (reg_wr_i && reg_addr_i == touch_cdc_pkg::ADDR_PWR_CTRL) begin
            pwr_ctrl_q <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == touch_cdc_pkg::ADDR_AMB_CTRL0) begin
            amb_ctrl0_q <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            for (int s = 0; s < touch_cdc_pkg::NUM_STAGES; s++) begin
                stage_cfg_q[4*s] <= touch_cdc_pkg::ROUTE_RST;
                stage_cfg_q[4*s+1] <= touch_cdc_pkg::OFFSET_RST;
                stage_cfg_q[4*s+2] <= touch_cdc_pkg::SENS_RST;
                stage_cfg_q[4*s+3] <= touch_cdc_pkg::THRESH_RST;
            end
        end else if (reg_wr_i && stage_sel) begin
            stage_cfg_q[stage_idx] <= reg_wdata_i;
        end
    end

    // Register reads, answered one cycle later
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 16'h0000;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                if (stage_sel) begin
                    reg_rdata_o <= stage_cfg_q[stage_idx];
                end else if (reg_addr_i == touch_cdc_pkg::ADDR_PWR_CTRL) begin
                    reg_rdata_o <= pwr_ctrl_q;
                end else if (reg_addr_i == touch_cdc_pkg::ADDR_AMB_CTRL0) begin
                    reg_rdata_o <= amb_ctrl0_q;
                end else if (reg_addr_i == touch_cdc_pkg::ADDR_INT_STATUS) begin
                    reg_rdata_o <= {8'h00, int_q};
                end else if (reg_addr_i == touch_cdc_pkg::ADDR_TOUCH_STATUS) begin
                    reg_rdata_o <= {8'h00, touch_q};
                end else begin
                    reg_rdata_o <= 16'h0000;
                end
            end
        end
    end

    // Power state
    always_comb begin
        pstate_d = pstate_q;
        if (shut_req) begin
            pstate_d = PS_SHUT;
        end else if (pwr_ctrl_q[1:0] == touch_cdc_pkg::MODE_FULL) begin
            pstate_d = PS_FULL;
        end else begin
            unique case (pstate_q)
                PS_FULL, PS_SHUT: pstate_d = PS_LP_IDLE;
                PS_LP_IDLE: begin
                    if (seq_done_q && |touch_q) begin
                        pstate_d = PS_LP_TOUCH;
                    end
                end
                PS_LP_TOUCH: begin
                    if (seq_done_q && !(|touch_q) && idle_cnt_q + 4'h1 >= idle_entry_timeout) begin
                        pstate_d = PS_LP_IDLE;
                    end
                end
                default: pstate_d = PS_SHUT;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pstate_q <= PS_FULL;
        end else begin
            pstate_q <= pstate_d;
        end
    end

    // Untouched sequences counted toward the idle timeout
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || pstate_q != PS_LP_TOUCH || (seq_done_q && |touch_q)) begin
            idle_cnt_q <= '0;
        end else if (seq_done_q) begin
            idle_cnt_q <= idle_cnt_q + 4'h1;
        end
    end

    // Cadence timer
    always_comb begin
        unique case (pstate_q)
            PS_LP_IDLE: period_len = 32'(WAKE_STEP_CYCLES) * {30'h0, wake_sel} + 32'(WAKE_STEP_CYCLES);
            PS_LP_TOUCH: period_len = 32'(TOUCHED_CYCLES);
            default: period_len = 32'(FULL_SEQ_CYCLES);
        endcase
    end
    assign tick = per_cnt_q >= period_len - 32'h1;

    always_ff @(posedge clk_sys_i) begin
        // A shorter wake interval must not inherit a count already past its end
        if (!rst_n_i || pstate_q == PS_SHUT || pstate_d != pstate_q || tick
            || (reg_wr_i && reg_addr_i == touch_cdc_pkg::ADDR_PWR_CTRL)) begin
            per_cnt_q <= 32'h0;
        end else begin
            per_cnt_q <= per_cnt_q + 32'h1;
        end
    end

    // Sequencer over all stages
    assign seq_start = tick && sq_q == SQ_IDLE && pstate_q != PS_SHUT && !shut_req;
    assign eval = sq_q == SQ_BUSY && conv_done_i;
    assign act_w = base_valid_q[stage_q] && crossed(stage_cfg_q[{stage_q, touch_cdc_pkg::STG_ROUTE}],
        conv_result_i, stage_cfg_q[{stage_q, touch_cdc_pkg::STG_OFFSET}], baseline_q[stage_q],
        stage_cfg_q[{stage_q, touch_cdc_pkg::STG_THRESH}]);

    always_ff @(posedge clk_sys_i) begin
        // Abort on the request itself, so no start leaks into the first shutdown cycle
        if (!rst_n_i || shut_req || pstate_q == PS_SHUT) begin
            sq_q <= SQ_IDLE;
            stage_q <= 3'h0;
            conv_start_o <= 1'b0;
            seq_done_q <= 1'b0;
            sense_route_o <= touch_cdc_pkg::ROUTE_RST;
        end else begin
            conv_start_o <= 1'b0;
            seq_done_q <= 1'b0;
            if (seq_start) begin
                sq_q <= SQ_BUSY;
                stage_q <= 3'h0;
                conv_start_o <= 1'b1;
                sense_route_o <= stage_cfg_q[{3'h0, touch_cdc_pkg::STG_ROUTE}];
            end else if (eval) begin
                if (stage_q == touch_cdc_pkg::LAST_STAGE) begin
                    sq_q <= SQ_IDLE;
                    seq_done_q <= 1'b1;
                end else begin
                    stage_q <= stage_q + 3'h1;
                    conv_start_o <= 1'b1;
                    sense_route_o <= stage_cfg_q[{stage_q + 3'h1, touch_cdc_pkg::STG_ROUTE}];
                end
            end
        end
    end
    assign conv_stage_o = stage_q;

    // Touch registration and ambient tracking
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            touch_q <= 8'h00;
            base_valid_q <= 8'h00;
            ambient_update_o <= 1'b0;
            for (int s = 0; s < touch_cdc_pkg::NUM_STAGES; s++) begin
                baseline_q[s] <= 16'h0000;
            end
        end else begin
            ambient_update_o <= eval && !act_w;
            if (eval) begin
                touch_q[stage_q] <= act_w;
                if (!act_w) begin
                    baseline_q[stage_q] <= conv_result_i + stage_cfg_q[{stage_q, touch_cdc_pkg::STG_OFFSET}];
                    base_valid_q[stage_q] <= 1'b1;
                end
            end
        end
    end

    // Sticky activation status, set beats write-one clear
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            int_q <= 8'h00;
        end else begin
            for (int s = 0; s < touch_cdc_pkg::NUM_STAGES; s++) begin
                if (eval && act_w && !touch_q[s] && stage_q == 3'(s)) begin
                    int_q[s] <= 1'b1;
                end else if (int_clr && reg_wdata_i[s]) begin
                    int_q[s] <= 1'b0;
                end
            end
        end
    end
    assign int_status_o = int_q;

    assign cdc_power_on_o = pstate_q != PS_SHUT;
    assign reduced_power_o = pstate_q == PS_LP_IDLE && sq_q == SQ_IDLE;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_last_eval;
        eval && stage_q == touch_cdc_pkg::LAST_STAGE && !shut_req;
    endsequence
    sequence s_new_touch;
        seq_done_q && |touch_q && pstate_q == PS_LP_IDLE && pwr_ctrl_q[1:0] == touch_cdc_pkg::MODE_LOW;
    endsequence

    chk_shut_entry: assert property (shut_req |=> pstate_q == PS_SHUT && !cdc_power_on_o)
        else $error("shutdown code did not power down");
    chk_shut_no_conv: assert property (pstate_q == PS_SHUT |-> !conv_start_o && sq_q == SQ_IDLE)
        else $error("conversion running in shutdown");
    chk_full_powered: assert property (pstate_q == PS_FULL |-> !reduced_power_o && cdc_power_on_o)
        else $error("full power entered reduced state");
    chk_full_mode_sel: assert property (pwr_ctrl_q[1:0] == touch_cdc_pkg::MODE_FULL |=> pstate_q == PS_FULL)
        else $error("mode 00 not full power");
    chk_seq_cadence: assert property (seq_start |=> conv_start_o && stage_q == 3'h0)
        else $error("cadence tick without sequence start");
    chk_seq_end: assert property (s_last_eval |=> seq_done_q ##1 !seq_done_q)
        else $error("sequence end not flagged once");
    chk_touch_enter: assert property (s_new_touch |=> pstate_q == PS_LP_TOUCH)
        else $error("touch did not select 25 ms cadence");
    chk_touch_period: assert property (pstate_q == PS_LP_TOUCH && tick |-> per_cnt_q == 32'(TOUCHED_CYCLES) - 32'h1)
        else $error("touched cadence length wrong");
    chk_wake_period: assert property (pstate_q == PS_LP_IDLE && tick
        |-> per_cnt_q == 32'(WAKE_STEP_CYCLES) * ({30'h0, wake_sel} + 32'h1) - 32'h1)
        else $error("wake interval length wrong");
    chk_timeout_exit: assert property (pstate_q == PS_LP_TOUCH && seq_done_q && !(|touch_q)
        && idle_cnt_q + 4'h1 >= idle_entry_timeout && pwr_ctrl_q[1:0] == touch_cdc_pkg::MODE_LOW
        |=> pstate_q == PS_LP_IDLE)
        else $error("timeout did not return to idle");
    chk_int_set: assert property (eval && act_w && !touch_q[stage_q] |=> int_q[$past(stage_q)])
        else $error("activation did not set status");
    chk_route_out: assert property (conv_start_o
        |-> sense_route_o == stage_cfg_q[{conv_stage_o, touch_cdc_pkg::STG_ROUTE}])
        else $error("stage route not presented");
endmodule : touch_cdc_ctrl
`default_nettype wire

// ==== core/touch_cdc_pkg.sv ====
/*
 * Constants for the touch converter power and input routing control:
 * register word addresses, field positions, reset values, mode and route
 * codes, and cadence timing. Assumes a 250 MHz system clock.
 */
package touch_cdc_pkg;
    localparam int NUM_STAGES = 8;
    localparam int NUM_PINS = 8;
    localparam logic [2:0] LAST_STAGE = 3'h7;

    // Register word addresses
    localparam logic [11:0] ADDR_PWR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_AMB_CTRL0 = 12'h002;
    localparam logic [11:0] ADDR_INT_STATUS = 12'h008;
    localparam logic [11:0] ADDR_TOUCH_STATUS = 12'h009;
    localparam logic [11:0] ADDR_STAGE_BASE = 12'h080;
    // Stage block: 4 words per stage, 8 stages
    localparam logic [1:0] STG_ROUTE = 2'h0;
    localparam logic [1:0] STG_OFFSET = 2'h1;
    localparam logic [1:0] STG_SENS = 2'h2;
    localparam logic [1:0] STG_THRESH = 2'h3;

    // Field positions
    localparam int PWR_MODE_LSB = 0;
    localparam int WAKE_LSB = 2;
    localparam int TIMEOUT_LSB = 0;
    localparam int TIMEOUT_W = 4;

    // Reset values
    localparam logic [15:0] PWR_CTRL_RST = 16'h0000;
    localparam logic [15:0] AMB_CTRL0_RST = 16'h0002;
    localparam logic [15:0] ROUTE_RST = 16'hFFFF;
    localparam logic [15:0] OFFSET_RST = 16'h0000;
    localparam logic [15:0] SENS_RST = 16'h0000;
    localparam logic [15:0] THRESH_RST = 16'h0100;

    // Power mode codes; bit 0 set means shutdown
    localparam logic [1:0] MODE_FULL = 2'b00;
    localparam logic [1:0] MODE_LOW = 2'b10;

    // Per-pin route codes
    localparam logic [1:0] ROUTE_FLOAT = 2'b00;
    localparam logic [1:0] ROUTE_POS = 2'b01;
    localparam logic [1:0] ROUTE_NEG = 2'b10;
    localparam logic [1:0] ROUTE_SHIELD = 2'b11;

    // Timing
    localparam int CLK_KHZ = 250000;
    localparam int TOUCHED_MS = 25;
    localparam int WAKE_STEP_MS = 200;
    localparam int FULL_SEQ_MS = 25;
    localparam int TOUCHED_CYCLES = TOUCHED_MS * CLK_KHZ;
    localparam int WAKE_STEP_CYCLES = WAKE_STEP_MS * CLK_KHZ;
    localparam int FULL_SEQ_CYCLES = FULL_SEQ_MS * CLK_KHZ;
endpackage : touch_cdc_pkg

// ==== dv/cdc_conv_model.sv ====
/*
 * Behavioural converter model for the touch control block: one result per
 * started stage, after a programmable latency, taken from a result table.
 * Assumes the same clock as the control block.
 */
`timescale 1ns/1ns
`default_nettype none
module cdc_conv_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [2:0] stage_i,
    input wire logic [127:0] results_i,
    input wire logic [3:0] lat_i,
    output logic done_o,
    output logic [15:0] result_o
);
    logic busy_q;
    logic [2:0] stage_q;
    logic [3:0] cnt_q;

    always @(posedge clk_i) begin
        done_o <= 1'b0;
        // Stale data must not look valid outside the done cycle
        result_o <= ~result_o;
        if (!rst_n_i) begin
            busy_q <= 1'b0;
            result_o <= 16'h0000;
        end else if (start_i) begin
            busy_q <= 1'b1;
            stage_q <= stage_i;
            cnt_q <= lat_i;
        end else if (busy_q) begin
            if (cnt_q == 4'h0) begin
                done_o <= 1'b1;
                result_o <= results_i[stage_q*16 +: 16];
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule : cdc_conv_model
`default_nettype wire

// ==== dv/test_touch_cdc_ctrl.sv ====
/*
 * Self-checking bench for the touch control block: register access,
 * cadence per power mode, shutdown, routing and touch registration.
 * Assumes shortened cadence parameters and the converter model.
 */
`timescale 1ns/1ns
`default_nettype none
module test_touch_cdc_ctrl;
    localparam int TC = 200;
    localparam int WS = 400;
    localparam int FS = 200;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [127:0] res = {8{16'h8000}};
    logic [3:0] lat = 4'h3;
    logic [15:0] rdata, conv_res, route;
    logic rvalid, conv_done, conv_start, pwr_on, reduced, amb;
    logic [2:0] stage;
    logic [7:0] int_st;
    logic [15:0] route_exp [8] = '{default: 16'hFFFF};
    int n_errors = 0;
    int total_checks = 0;
    int n0 = 0;
    int last0 = 0;
    int prev0 = 0;
    int n_amb = 0;
    int cyc = 0;
    int s;

    touch_cdc_ctrl #(.TOUCHED_CYCLES(TC), .WAKE_STEP_CYCLES(WS), .FULL_SEQ_CYCLES(FS))
    i_touch_cdc_ctrl (.clk_sys_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .conv_done_i(conv_done), .conv_result_i(conv_res),
        .conv_start_o(conv_start), .conv_stage_o(stage), .sense_route_o(route),
        .cdc_power_on_o(pwr_on), .reduced_power_o(reduced), .ambient_update_o(amb),
        .int_status_o(int_st));
    cdc_conv_model i_cdc_conv_model (.clk_i(clk), .rst_n_i(rst_n), .start_i(conv_start),
        .stage_i(stage), .results_i(res), .lat_i(lat), .done_o(conv_done),
        .result_o(conv_res));

    always #2 clk = ~clk;

    task check(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    always @(posedge clk) begin
        cyc++;
        if (amb === 1'b1) n_amb++;
        if (conv_start === 1'b1) begin
            check(route, route_exp[stage], "stage route");
            if (stage === 3'h0) begin
                n0++;
                prev0 = last0;
                last0 = cyc;
            end
        end
    end

    task wr_reg(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        #1 addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1 wr = 1'b0;
    endtask : wr_reg

    task rd_chk(input logic [11:0] a, input logic [15:0] exp);
        @(posedge clk);
        #1 addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1 rd = 1'b0;
        check({15'h0000, rvalid}, 16'h0001, "read valid");
        check(rdata, exp, "read data");
    endtask : rd_chk

    task wait_seqs(input int k);
        int t;
        t = n0 + k;
        for (int i = 0; i < 20000 && n0 < t; i++) @(posedge clk);
        #1;
        check({15'h0000, n0 >= t}, 16'h0001, "sequence wait");
    endtask : wait_seqs

    task summarize();
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        #(60000 * 4);
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        rd_chk(touch_cdc_pkg::ADDR_PWR_CTRL, 16'h0000);
        rd_chk(touch_cdc_pkg::ADDR_AMB_CTRL0, 16'h0002);
        rd_chk(touch_cdc_pkg::ADDR_STAGE_BASE, 16'hFFFF);
        rd_chk(touch_cdc_pkg::ADDR_STAGE_BASE + 12'h003, 16'h0100);
        rd_chk(12'h7FF, 16'h0000);
        // Unused pins go to the shield; stage 3 uses all four codes
        route_exp[0] = 16'hFFFD;
        route_exp[1] = 16'hFFFE;
        route_exp[2] = 16'hFFF0;
        route_exp[3] = 16'hE4FF;
        for (int i = 0; i < 4; i++) wr_reg(12'h080 + 12'(4 * i), route_exp[i]);
        wr_reg(12'h096, 16'hA5C3);
        rd_chk(12'h096, 16'hA5C3);
        rd_chk(12'h09A, 16'h0000);
        s = n_amb;
        wait_seqs(3);
        check({15'h0000, n_amb >= s + 16}, 16'h0001, "ambient updates");
        check(16'(last0 - prev0), 16'(FS), "full power cadence");
        check({14'h0000, pwr_on, reduced}, 16'h0002, "full power state");
        // Touch: falling on positive route, rising on negative, small step ignored
        #1 res[15:0] = 16'h7E00;
        res[31:16] = 16'h8200;
        res[47:32] = 16'h8080;
        lat = 4'h9;
        wait_seqs(2);
        check({8'h00, int_st}, 16'h0003, "activation status");
        rd_chk(touch_cdc_pkg::ADDR_INT_STATUS, 16'h0003);
        res = {8{16'h8000}};
        lat = 4'h2;
        wait_seqs(2);
        wr_reg(touch_cdc_pkg::ADDR_INT_STATUS, 16'h00FF);
        rd_chk(touch_cdc_pkg::ADDR_INT_STATUS, 16'h0000);
        for (int m = 1; m < 4; m += 2) begin
            wr_reg(touch_cdc_pkg::ADDR_PWR_CTRL, 16'(m));
            repeat (4) @(posedge clk);
            s = n0;
            repeat (2 * FS) @(posedge clk);
            #1 check({15'h0000, pwr_on}, 16'h0000, "shutdown power");
            check(16'(n0 - s), 16'h0000, "no conversion in shutdown");
        end
        for (int k = 0; k < 4; k++) begin
            wr_reg(touch_cdc_pkg::ADDR_PWR_CTRL, {12'h000, 2'(k), 2'b10});
            // Let the sequence in flight finish before looking for the idle state
            repeat (60) @(posedge clk);
            #1 check({14'h0000, pwr_on, reduced}, 16'h0003, "low power idle");
            wait_seqs(2);
            check(16'(last0 - prev0), 16'(WS * (k + 1)), "wake interval");
        end
        wr_reg(touch_cdc_pkg::ADDR_PWR_CTRL, 16'h0002);
        wr_reg(touch_cdc_pkg::ADDR_AMB_CTRL0, 16'h0003);
        #1 res[15:0] = 16'h7E00;
        wait_seqs(3);
        check(16'(last0 - prev0), 16'(TC), "touched cadence");
        check({15'h0000, reduced}, 16'h0000, "touched not reduced");
        res[15:0] = 16'h8000;
        wait_seqs(1);
        s = n0;
        for (int i = 0; i < 3000 && reduced !== 1'b1; i++) @(posedge clk);
        #1 check({15'h0000, reduced}, 16'h0001, "back to idle");
        check({15'h0000, n0 >= s + 1}, 16'h0001, "idle after timeout");
        wait_seqs(2);
        check(16'(last0 - prev0), 16'(WS), "reverted interval");
        summarize();
    end
endmodule : test_touch_cdc_ctrl
`default_nettype wire
